// ### src/uhq_pkg.sv
// uhq_pkg: constants and types for the usb schedule engine and wire coder
// assumes a single controller clock; shared by the top module and its testbench
package uhq_pkg;
  // wishbone byte offsets
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_FRAME = 8'h04;
  localparam logic [7:0] ADR_STAT = 8'h08;
  localparam logic [7:0] ADR_TX = 8'h0C;
  localparam logic [7:0] ADR_RX = 8'h10;
  // link pointer bits
  localparam int LP_T = 0;
  localparam int LP_Q = 1;
  localparam int LP_VF = 2;
  localparam logic [31:0] WORD2_OFS = 32'h4;
  // tx command and rx status field positions
  localparam int TXC_PID = 0;
  localparam int TXC_ADDR = 4;
  localparam int TXC_ENDP = 11;
  localparam int RX_OK_BIT = 4;
  localparam int RX_BAD_BIT = 5;
  // reset values
  localparam logic RUN_RST = 1'b0;
  localparam logic [31:0] FRAME_RST = 32'h0;
  // pid types
  localparam logic [3:0] PID_OUT = 4'h1;
  localparam logic [3:0] PID_IN = 4'h9;
  localparam logic [3:0] PID_SOF = 4'h5;
  localparam logic [3:0] PID_SETUP = 4'hD;
  localparam logic [3:0] PID_DATA0 = 4'h3;
  localparam logic [3:0] PID_DATA1 = 4'hB;
  localparam logic [3:0] PID_ACK = 4'h2;
  localparam logic [3:0] PID_NAK = 4'hA;
  localparam logic [3:0] PID_STALL = 4'hE;
  localparam logic [3:0] PID_PRE = 4'hC;
  // wire coding
  localparam logic [7:0] SYNC_BYTE = 8'h80;
  localparam logic [2:0] STUFF_RUN = 3'h6;
  localparam logic [4:0] LEN_TOKEN = 5'h1B;
  localparam logic [4:0] LEN_SHORT = 5'h10;
  localparam logic [1:0] EOP_LEN = 2'h2;
  // execution results
  localparam logic [1:0] RES_DATA = 2'h0;
  localparam logic [1:0] RES_NULL = 2'h1;
  localparam logic [1:0] RES_ERR = 2'h2;
  localparam logic [1:0] RES_NAK = 2'h3;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_PTR = 4'h1, ST_TD0 = 4'h3, ST_TD1 = 4'h2,
    ST_EXEC = 4'h6, ST_WB = 4'h7, ST_QH0 = 4'h5, ST_QH1 = 4'h4
  } uhq_state_t;
  typedef enum logic [1:0] {
    TX_IDLE = 2'h0, TX_BITS = 2'h1, TX_EOP = 2'h3
  } uhq_tx_t;
endpackage

// ### src/uhq_top.sv
// uhq_top: schedule walker, packet transmitter and pid checker
// assumes a same-clock memory port, executor and pid receiver
//
// Function
// - breadth-first: element pointer, run descriptor, write back, then head
// - failed queued descriptor: no advance, continue through head pointer
// - success with depth-first flag set: follow descriptor link pointer, or head pointer if that link has terminate set
// - on advance copy descriptor link pointer into element pointer
// - on queue head keep a copy and enter in-queue state
// - never advance on error, even with exhausted error count
// - advance on data or null data; error or nak retries element
// - outside queue: terminate ends frame, else next descriptor or head
// - element terminate set: empty queue, follow head or end frame
// - element queue flag set: fetch nested queue head
// - depth-first clear: update element, then follow head pointer
// - nrzi: one holds the line level, zero toggles it
// - insert zero after six consecutive ones before nrzi
// - stuffing spans sync to end, even just before eop
// - every field sent least significant bit first
// - eight-bit sync, line shows kjkjkjkk after idle
// - pid: type in bits 0-3, complement in bits 4-7
// - bad check field or undefined type: packet ignored
// - token codes out 0001, in 1001, sof 0101, setup 1101
// - data0 0011, data1 1011, ack 0010
// - nak 1010, stall 1110, pre 1100
// - in, setup, out tokens carry address then endpoint
// - terminate in head pointer means no more work this frame
// - breadth-first by default, depth-first per descriptor flag
//
// The register addresses and the Wishbone slave port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module uhq_top
  import uhq_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic frame_tick,
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  output logic exec_req,
  output logic [31:0] exec_token,
  input wire logic exec_done,
  input wire logic [1:0] exec_result,
  output logic usb_dp_o,
  output logic usb_dm_o,
  output logic usb_oe_o,
  input wire logic rx_pid_valid,
  input wire logic [7:0] rx_pid_byte,
  output logic rx_pid_ok,
  output logic rx_pid_bad,
  output logic [3:0] rx_pid_type
);
  uhq_state_t state_reg, state_next;
  logic run_reg;
  logic [31:0] frame_reg;
  logic [31:0] cur_ptr_reg, cur_ptr_next;
  logic in_q_reg, in_q_next;
  logic [31:0] qh_addr_reg, qh_hlp_reg, qh_elp_reg;
  logic [31:0] td_link_reg;
  logic bad_sticky_reg;
  uhq_tx_t tx_state_reg;
  logic [26:0] tx_sh_reg;
  logic [4:0] tx_left_reg;
  logic [2:0] tx_ones_reg;
  logic [1:0] tx_eop_reg;

  // bus decode
  wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire bus_wr = bus_req && wb_we_i;
  wire wr_ctrl = bus_wr && wb_adr_i == ADR_CTRL && wb_sel_i[0];
  wire wr_frame = bus_wr && wb_adr_i == ADR_FRAME;
  wire wr_tx = bus_wr && wb_adr_i == ADR_TX && wb_sel_i[0];
  wire wr_rx = bus_wr && wb_adr_i == ADR_RX && wb_sel_i[0];
  wire tx_busy = tx_state_reg != TX_IDLE;
  wire [31:0] stat_word = {26'h0, tx_busy, in_q_reg, state_reg};
  wire [31:0] rx_word = {26'h0, bad_sticky_reg, rx_pid_ok, rx_pid_type};
  logic [31:0] rd_word;
  always_comb begin
    if (wb_adr_i == ADR_CTRL) begin
      rd_word = {31'h0, run_reg};
    end else if (wb_adr_i == ADR_FRAME) begin
      rd_word = frame_reg;
    end else if (wb_adr_i == ADR_STAT) begin
      rd_word = stat_word;
    end else if (wb_adr_i == ADR_RX) begin
      rd_word = rx_word;
    end else begin
      rd_word = 32'h0;
    end
  end

  // every access, mapped or not, is acked one cycle later
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      run_reg <= RUN_RST;
      frame_reg <= FRAME_RST;
    end else if (ce) begin
      wb_ack_o <= bus_req;
      if (bus_req) begin
        wb_dat_o <= rd_word;
      end
      if (wr_ctrl) begin
        run_reg <= wb_dat_i[0];
      end
      for (int i = 0; i < 4; i++) begin
        if (wr_frame && wb_sel_i[i]) begin
          frame_reg[i*8 +: 8] <= wb_dat_i[i*8 +: 8];
        end
      end
    end
  end

  // schedule walker
  wire [31:0] ptr_addr = {cur_ptr_reg[31:4], 4'h0};
  wire mem_st = state_reg inside {ST_TD0, ST_TD1, ST_QH0, ST_QH1, ST_WB};
  wire mem_done = mem_req && mem_ack;
  wire ex_done = exec_req && exec_done;
  wire advance = exec_result == RES_DATA || exec_result == RES_NULL;
  logic [31:0] addr_next;
  always_comb begin
    case (state_reg)
      ST_TD1: addr_next = ptr_addr + WORD2_OFS;
      ST_QH1: addr_next = ptr_addr + WORD2_OFS;
      ST_WB: addr_next = qh_addr_reg + WORD2_OFS;
      default: addr_next = ptr_addr;
    endcase
  end

  always_comb begin
    state_next = state_reg;
    cur_ptr_next = cur_ptr_reg;
    in_q_next = in_q_reg;
    case (state_reg)
      ST_IDLE: begin
        if (frame_tick && run_reg) begin
          cur_ptr_next = frame_reg;
          in_q_next = 1'b0;
          state_next = ST_PTR;
        end
      end
      ST_PTR: begin
        if (cur_ptr_reg[LP_T]) begin
          state_next = ST_IDLE;
          in_q_next = 1'b0;
        end else if (cur_ptr_reg[LP_Q]) begin
          state_next = ST_QH0;
        end else begin
          state_next = ST_TD0;
        end
      end
      ST_QH0: begin
        if (mem_done) begin
          state_next = ST_QH1;
        end
      end
      ST_QH1: begin
        if (mem_done) begin
          in_q_next = 1'b1;
          state_next = ST_PTR;
          if (mem_rdata[LP_T]) begin
            cur_ptr_next = qh_hlp_reg;
            // empty queue: head pointer leads outside this queue
            in_q_next = 1'b0;
          end else begin
            cur_ptr_next = mem_rdata;
          end
        end
      end
      ST_TD0: begin
        if (mem_done) begin
          state_next = ST_TD1;
        end
      end
      ST_TD1: begin
        if (mem_done) begin
          state_next = ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (ex_done) begin
          state_next = ST_PTR;
          if (!in_q_reg) begin
            cur_ptr_next = td_link_reg;
          end else if (advance) begin
            state_next = ST_WB;
          end else begin
            // retry element next frame
            cur_ptr_next = qh_hlp_reg;
            in_q_next = 1'b0;
          end
        end
      end
      ST_WB: begin
        if (mem_done) begin
          state_next = ST_PTR;
          if (td_link_reg[LP_VF] && !td_link_reg[LP_T]) begin
            cur_ptr_next = td_link_reg;
          end else begin
            cur_ptr_next = qh_hlp_reg;
            in_q_next = 1'b0;
          end
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      cur_ptr_reg <= 32'h0;
      in_q_reg <= 1'b0;
    end else if (ce) begin
      state_reg <= state_next;
      cur_ptr_reg <= cur_ptr_next;
      in_q_reg <= in_q_next;
    end
  end

  // queue head copy and descriptor words
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      qh_addr_reg <= 32'h0;
      qh_hlp_reg <= 32'h0;
      qh_elp_reg <= 32'h0;
      td_link_reg <= 32'h0;
      exec_token <= 32'h0;
    end else if (ce && mem_done) begin
      if (state_reg == ST_QH0) begin
        qh_addr_reg <= ptr_addr;
        qh_hlp_reg <= mem_rdata;
      end
      if (state_reg == ST_QH1) begin
        qh_elp_reg <= mem_rdata;
      end
      if (state_reg == ST_TD0) begin
        td_link_reg <= mem_rdata;
      end
      if (state_reg == ST_TD1) begin
        exec_token <= mem_rdata;
      end
    end
  end

  // memory and executor handshakes; request held until answered
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 32'h0;
      mem_wdata <= 32'h0;
      exec_req <= 1'b0;
    end else if (ce) begin
      if (mem_done) begin
        mem_req <= 1'b0;
      end else if (mem_st && !mem_req) begin
        mem_req <= 1'b1;
        mem_addr <= addr_next;
        mem_we <= state_reg == ST_WB;
        mem_wdata <= td_link_reg;
      end
      if (ex_done) begin
        exec_req <= 1'b0;
      end else if (state_reg == ST_EXEC && !exec_req) begin
        exec_req <= 1'b1;
      end
    end
  end

  // transmitter: one bit per enabled cycle
  wire [3:0] cmd_pid = wb_dat_i[TXC_PID +: 4];
  wire cmd_tok = cmd_pid == PID_OUT || cmd_pid == PID_IN ||
                 cmd_pid == PID_SETUP;
  wire [26:0] cmd_bits = {wb_dat_i[TXC_ENDP +: 4], wb_dat_i[TXC_ADDR +: 7],
                          ~cmd_pid, cmd_pid, SYNC_BYTE};
  wire do_stuff = tx_ones_reg == STUFF_RUN;
  wire cur_bit = tx_sh_reg[0];

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tx_state_reg <= TX_IDLE;
      tx_sh_reg <= 27'h0;
      tx_left_reg <= 5'h0;
      tx_ones_reg <= 3'h0;
      tx_eop_reg <= 2'h0;
      usb_dp_o <= 1'b1;
      usb_dm_o <= 1'b0;
      usb_oe_o <= 1'b0;
    end else if (ce) begin
      case (tx_state_reg)
        TX_IDLE: begin
          usb_dp_o <= 1'b1;
          usb_dm_o <= 1'b0;
          usb_oe_o <= 1'b0;
          if (wr_tx) begin
            tx_state_reg <= TX_BITS;
            tx_sh_reg <= cmd_bits;
            tx_left_reg <= cmd_tok ? LEN_TOKEN : LEN_SHORT;
            tx_ones_reg <= 3'h0;
          end
        end
        TX_BITS: begin
          usb_oe_o <= 1'b1;
          if (do_stuff) begin
            // stuffed zero: toggle, even as the last bit
            usb_dp_o <= ~usb_dp_o;
            usb_dm_o <= usb_dp_o;
            tx_ones_reg <= 3'h0;
          end else if (tx_left_reg == 5'h0) begin
            tx_state_reg <= TX_EOP;
            tx_eop_reg <= EOP_LEN;
            usb_dp_o <= 1'b0;
            usb_dm_o <= 1'b0;
          end else begin
            if (!cur_bit) begin
              usb_dp_o <= ~usb_dp_o;
              usb_dm_o <= usb_dp_o;
            end
            tx_ones_reg <= cur_bit ? tx_ones_reg + 3'h1 : 3'h0;
            tx_sh_reg <= {1'b0, tx_sh_reg[26:1]};
            tx_left_reg <= tx_left_reg - 5'h1;
          end
        end
        TX_EOP: begin
          if (tx_eop_reg == 2'h1) begin
            tx_state_reg <= TX_IDLE;
            usb_dp_o <= 1'b1;
          end
          tx_eop_reg <= tx_eop_reg - 2'h1;
        end
        default: begin
          tx_state_reg <= TX_IDLE;
        end
      endcase
    end
  end

  // pid checker; a corrupt pid drops the packet
  wire [3:0] rpid = rx_pid_byte[3:0];
  wire rx_chk = rx_pid_byte[7:4] == ~rpid;
  wire rx_def = rpid inside {PID_OUT, PID_IN, PID_SOF, PID_SETUP,
    PID_DATA0, PID_DATA1, PID_ACK, PID_NAK, PID_STALL,
    PID_PRE};
  wire rx_good = rx_chk && rx_def;
  wire rx_clr = wr_rx && wb_dat_i[RX_BAD_BIT];

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rx_pid_ok <= 1'b0;
      rx_pid_bad <= 1'b0;
      rx_pid_type <= 4'h0;
      bad_sticky_reg <= 1'b0;
    end else if (ce) begin
      rx_pid_ok <= rx_pid_valid && rx_good;
      rx_pid_bad <= rx_pid_valid && !rx_good;
      if (rx_pid_valid && rx_good) begin
        rx_pid_type <= rpid;
      end
      // new error wins over a clear in the same cycle
      if (rx_pid_valid && !rx_good) begin
        bad_sticky_reg <= 1'b1;
      end else if (rx_clr) begin
        bad_sticky_reg <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  AST_NO_ADV_ON_ERR: assert property (
    ce && state_reg == ST_EXEC && ex_done && in_q_reg && !advance
    |=> state_reg == ST_PTR && cur_ptr_reg == $past(qh_hlp_reg))
    else $error("queue advanced on error");
  AST_ADV_WB: assert property (
    ce && state_reg == ST_EXEC && ex_done && in_q_reg && advance
    |=> state_reg == ST_WB)
    else $error("no write-back on success");
  AST_WB_DATA: assert property (
    mem_req && mem_we
    |-> mem_wdata == td_link_reg && mem_addr == qh_addr_reg + WORD2_OFS)
    else $error("bad write-back");
  AST_VF_FOLLOW: assert property (
    ce && state_reg == ST_WB && mem_done && td_link_reg[LP_VF] &&
    !td_link_reg[LP_T] |=> cur_ptr_reg == $past(td_link_reg) && in_q_reg)
    else $error("depth-first link not followed");
  AST_BF_NEXT: assert property (
    ce && state_reg == ST_WB && mem_done && !td_link_reg[LP_VF]
    |=> cur_ptr_reg == $past(qh_hlp_reg) && !in_q_reg)
    else $error("breadth-first head not followed");
  AST_QH_CTX: assert property (
    ce && state_reg == ST_QH1 && mem_done
    |=> in_q_reg == !$past(mem_rdata[LP_T]))
    else $error("queue context not entered");
  AST_EMPTY_Q: assert property (
    ce && state_reg == ST_QH1 && mem_done && mem_rdata[LP_T]
    |=> cur_ptr_reg == $past(qh_hlp_reg) && !in_q_reg)
    else $error("empty queue not skipped");
  AST_END_FRAME: assert property (
    ce && state_reg == ST_PTR && cur_ptr_reg[LP_T] |=> state_reg == ST_IDLE)
    else $error("frame not ended");
  AST_STUFF: assert property (
    ce && tx_state_reg == TX_BITS && do_stuff
    |=> usb_dp_o != $past(usb_dp_o) && tx_ones_reg == 3'h0)
    else $error("stuffed zero missing");
  AST_NRZI_ONE: assert property (
    ce && tx_state_reg == TX_BITS && !do_stuff && tx_left_reg != 5'h0 &&
    cur_bit |=> usb_dp_o == $past(usb_dp_o))
    else $error("one bit toggled line");
  AST_PID_BAD: assert property (
    ce && rx_pid_valid && rx_pid_byte[7:4] != ~rx_pid_byte[3:0]
    |=> rx_pid_bad && !rx_pid_ok)
    else $error("corrupt pid accepted");
  COV_DEPTH: cover property (ce && state_reg == ST_WB && mem_done &&
    td_link_reg[LP_VF]);
  COV_RETRY: cover property (ce && ex_done && in_q_reg && !advance);
  COV_STUFF: cover property (ce && tx_state_reg == TX_BITS && do_stuff);
  COV_TOKEN: cover property (ce && wr_tx && !tx_busy && cmd_tok);
endmodule
`default_nettype wire

// ### verif/uhq_far_model.sv
// uhq_far_model: schedule memory and transaction executor on the far side
// assumes same-clock handshakes; answers after a random 0..3 cycle delay
`timescale 1ns/10ps
`default_nettype none
module uhq_far_model (
  input wire logic clk_sys,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  output var logic mem_ack,
  output var logic [31:0] mem_rdata,
  input wire logic exec_req,
  input wire logic [31:0] exec_token,
  output var logic exec_done,
  output var logic [1:0] exec_result
);
  logic [31:0] m [0:1023];
  int n_ex = 0;
  int n_wr = 0;
  initial begin
    mem_ack = 1'b0;
    mem_rdata = 32'h0;
    forever begin
      @(posedge clk_sys);
      if (mem_req === 1'b1) begin
        repeat ($urandom_range(0, 3)) @(posedge clk_sys);
        if (mem_we === 1'b1) begin
          m[mem_addr[11:2]] <= mem_wdata;
          n_wr++;
        end else begin
          mem_rdata <= m[mem_addr[11:2]];
        end
        mem_ack <= 1'b1;
        @(posedge clk_sys);
        mem_ack <= 1'b0;
        // stale data inverted so a late read cannot pass by luck
        mem_rdata <= ~mem_rdata;
      end
    end
  end
  initial begin
    exec_done = 1'b0;
    exec_result = 2'h0;
    forever begin
      @(posedge clk_sys);
      if (exec_req === 1'b1) begin
        repeat ($urandom_range(0, 3)) @(posedge clk_sys);
        // result code carried in the low bits of the token word
        exec_result <= exec_token[1:0];
        exec_done <= 1'b1;
        n_ex++;
        @(posedge clk_sys);
        exec_done <= 1'b0;
        exec_result <= ~exec_result;
      end
    end
  end
endmodule
`default_nettype wire

// ### verif/uhq_top_tb.sv
// uhq_top_tb: self-checking bench for the schedule walker and wire coder
// assumes uhq_far_model as memory and executor; ce and sel held high
`timescale 1ns/10ps
`default_nettype none
module uhq_top_tb;
  import uhq_pkg::*;
  logic clk_sys = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic tick = 1'b0, rxv = 1'b0;
  logic [7:0] adr = 8'h00, rxb = 8'h00;
  logic [31:0] wdat = 32'h0, q;
  logic [31:0] wb_dat_o, mem_addr, mem_wdata, mem_rdata, exec_token;
  logic wb_ack_o, mem_req, mem_we, mem_ack, exec_req, exec_done;
  logic usb_dp_o, usb_dm_o, usb_oe_o, rx_pid_ok, rx_pid_bad;
  logic [1:0] exec_result;
  logic [3:0] rx_pid_type;
  int n_errors = 0, check_count = 0;
  logic [3:0] codes [10] = '{4'h1, 4'h9, 4'h5, 4'hD, 4'h3, 4'hB, 4'h2,
                             4'hA, 4'hE, 4'hC};
  always #12.5 clk_sys = ~clk_sys;
  uhq_top dut_u (.clk_sys(clk_sys), .rst(rst), .ce(1'b1), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .frame_tick(tick), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .exec_req(exec_req), .exec_token(exec_token),
    .exec_done(exec_done), .exec_result(exec_result), .usb_dp_o(usb_dp_o),
    .usb_dm_o(usb_dm_o), .usb_oe_o(usb_oe_o), .rx_pid_valid(rxv),
    .rx_pid_byte(rxb), .rx_pid_ok(rx_pid_ok), .rx_pid_bad(rx_pid_bad),
    .rx_pid_type(rx_pid_type));
  uhq_far_model mu (.clk_sys(clk_sys), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .exec_req(exec_req), .exec_token(exec_token),
    .exec_done(exec_done), .exec_result(exec_result));
  task automatic chk(input logic [34:0] g, input logic [34:0] e,
                     input string m);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_sys);
      t++;
    end while (wb_ack_o !== 1'b1 && t < 40);
    chk(wb_ack_o, 1'b1, "bus ack");
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  function automatic logic good(input logic [7:0] b);
    return b[7:4] == ~b[3:0] && (b[3:0] inside {codes});
  endfunction
  task automatic tx(input logic [3:0] p, input logic [6:0] a,
                    input logic [3:0] e);
    logic [34:0] ex, got;
    int n, ones, se, t;
    logic prev, b, tok;
    tok = (p == 4'h1 || p == 4'h9 || p == 4'hD);
    ex = {e, a, ~p, p, SYNC_BYTE};
    if (!tok) ex[34:16] = '0;
    got = '0;
    n = 0;
    ones = 0;
    se = 0;
    prev = 1'b1;
    t = 0;
    wb(1'b1, ADR_TX, {17'h0, e, a, p});
    while (usb_oe_o !== 1'b1 && t < 5) begin
      @(posedge clk_sys);
      t++;
    end
    while (usb_oe_o === 1'b1 && t < 90) begin
      if (usb_dp_o === 1'b0 && usb_dm_o === 1'b0) se++;
      else if (se == 0) begin
        b = (usb_dp_o === prev);
        chk(usb_dm_o, !usb_dp_o, "dm level");
        prev = usb_dp_o;
        if (ones == 6) begin
          chk(b, 1'b0, "stuffed bit");
          ones = 0;
        end else begin
          if (n < 35) got[n] = b;
          n++;
          ones = b ? ones + 1 : 0;
        end
      end
      @(posedge clk_sys);
      t++;
    end
    chk(ones == 6, 1'b0, "stuff before eop");
    chk(n, tok ? 27 : 16, "bit count");
    chk(got, ex, "packet bits");
    chk(se, 2, "eop length");
  endtask
  task automatic frm(input logic [1:0] r, input int ne, input int nw,
                     input logic [31:0] el);
    int t;
    mu.m[10'h0C1] = {30'h0, r};
    mu.n_ex = 0;
    mu.n_wr = 0;
    t = 0;
    @(posedge clk_sys);
    tick <= 1'b1;
    @(posedge clk_sys);
    tick <= 1'b0;
    do begin
      wb(1'b0, ADR_STAT, 32'h0);
      t++;
    end while (q[3:0] !== ST_IDLE && t < 200);
    chk(t < 200, 1'b1, "frame end");
    chk(mu.n_ex, ne, "executions");
    chk(mu.n_wr, nw, "write-backs");
    chk(mu.m[10'h041], el, "element pointer");
    $display("test frame result %0d done", r);
  endtask
  task results();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #(25ns * 40000);
    n_errors++;
    results();
  end
  initial begin
    void'($urandom(32'h0b6d));
    repeat (6) @(posedge clk_sys);
    chk({usb_dp_o, usb_dm_o, usb_oe_o, mem_req, exec_req}, 5'h10, "reset");
    rst <= 1'b0;
    wb(1'b0, ADR_CTRL, 32'h0);
    chk(q[0], RUN_RST, "run reset");
    wb(1'b0, ADR_FRAME, 32'h0);
    chk(q, FRAME_RST, "frame reset");
    wb(1'b1, 8'h20, 32'hFFFF);
    wb(1'b0, 8'h20, 32'h0);
    chk(q, 32'h0, "unmapped read");
    $display("test registers done");
    for (int i = 0; i < 256; i++) begin
      @(posedge clk_sys);
      rxv <= 1'b1;
      rxb <= i[7:0];
      @(posedge clk_sys);
      rxv <= 1'b0;
      @(posedge clk_sys);
      chk(rx_pid_ok, good(i[7:0]), "pid ok");
      chk(rx_pid_bad, !good(i[7:0]), "pid bad");
      if (good(i[7:0])) chk(rx_pid_type, i[3:0], "pid type");
    end
    // last good byte of the sweep is 8'hE1; the last byte was corrupt
    wb(1'b0, ADR_RX, 32'h0);
    chk(q[5:0], {2'b10, PID_OUT}, "rx sticky");
    wb(1'b1, ADR_RX, 32'h20);
    wb(1'b0, ADR_RX, 32'h0);
    chk(q[5:0], {2'b00, PID_OUT}, "rx clear");
    $display("test pid receive done");
    // corner cases: long one runs, and a stuff bit right before eop
    tx(4'h1, 7'h7F, 4'hF);
    tx(4'h9, 7'h60, 4'hF);
    for (int i = 0; i < 10; i++) begin
      tx(codes[i], 7'($urandom_range(0, 127)), 4'($urandom_range(0, 15)));
    end
    $display("test transmit done");
    mu.m[10'h040] = 32'h1;
    mu.m[10'h041] = 32'h300;
    mu.m[10'h0C0] = 32'h400;
    mu.m[10'h100] = 32'h1;
    mu.m[10'h101] = {30'h0, RES_NULL};
    wb(1'b1, ADR_FRAME, 32'h102);
    wb(1'b1, ADR_CTRL, 32'h1);
    frm(RES_NAK, 1, 0, 32'h300);
    frm(RES_ERR, 1, 0, 32'h300);
    mu.m[10'h0C0] = 32'h404;
    frm(RES_DATA, 2, 2, 32'h1);
    frm(RES_DATA, 0, 0, 32'h1);
    wb(1'b1, ADR_FRAME, 32'h400);
    frm(RES_DATA, 1, 0, 32'h1);
    results();
  end
endmodule
`default_nettype wire
